// [include/wdt_cfg.svh]
// Purpose: shared constants of the run-away watchdog
// Assumes: 25 MHz system clock
// Notes: offsets are byte addresses on APB
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_CLK_NS 40
`define WDT_TICK_NS 10240000
`define WDT_CNT_W 9
`define WDT_CNT_RST 9'h0ff
`define WDT_CNT_NEG_LIM 9'h1f0
`define WDT_CNT_ZERO 9'h000
`define WDT_CNT_ONE 9'h001
`define WDT_GUARD_LSB 9
`define WDT_GUARD_W 7
`define WDT_OFS_CNT 12'h000
`define WDT_OFS_CTRL 12'h004
`define WDT_OFS_FRZ_SET 12'h008
`define WDT_OFS_FRZ_CLR 12'h00c
`define WDT_OFS_IRQ_STAT 12'h010
`define WDT_OFS_IRQ_MASK 12'h014
`define WDT_OFS_STATUS 12'h018
`define WDT_BIT_SEL 0
`define WDT_BIT_FRZ 0
`define WDT_IRQ_W 2
`define WDT_IRQ_NMI 0
`define WDT_IRQ_REJ 1
`endif

// [include/wdt_pkg.sv]
// Purpose: types of the run-away watchdog
// Assumes: wdt_cfg.svh gives the widths
// Notes: none
`include "wdt_cfg.svh"
package wdt_pkg;
  typedef struct packed {
    logic [15:0] unused;
    logic [`WDT_GUARD_W-1:0] write_guard_field;
    logic [`WDT_CNT_W-1:0] value;
  } wdt_cnt_word_t;
  typedef struct packed {
    logic reset_req;
    logic sw_frozen;
    logic debug_frozen;
  } wdt_status_t;
endpackage : wdt_pkg

// [rtl/wdt_top.sv]
// Purpose: run-away watchdog with interrupt-first or reset-at-zero mode
// Assumes: debug halt status comes from logic on the same clock
// Notes: registers over APB, zero wait state with one setup cycle
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Overview of operation
// - decrement by one each tick unless frozen or a reset request is pending
// - counter loads 255 on reset
// - below zero count continues with bit 8
// - mode 0: interrupt at 0, reset at -16
// - mode 1: reset at zero or below
// - system reset reloads counter to 255
// - debug halt always freezes counter
// - software freeze only when mode is 0
// - freeze clear resumes from held value
// - mode bit set only, reset clears
module wdt_top #(
  parameter int TICK_CYCLES = `WDT_TICK_NS / `WDT_CLK_NS
) (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic DEBUG_HALT_STATUS_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic NMI_O,
  output logic SYS_RST_REQ_O,
  output logic IRQ_O
);
  localparam int DIV_W = $clog2(TICK_CYCLES);

  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic [`WDT_CNT_W-1:0] cnt_q;
  logic [`WDT_CNT_W-1:0] cnt_dec;
  logic sel_q;
  logic sw_frz_q;
  logic nmi_q;
  logic rst_req_q;
  logic [`WDT_IRQ_W-1:0] stat_q;
  logic [`WDT_IRQ_W-1:0] mask_q;
  logic [`WDT_IRQ_W-1:0] stat_set;
  logic irq_q;
  logic [31:0] rdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wr_en;
  logic mapped;
  logic frozen;
  logic count_en;
  logic cnt_wr;
  logic guard_ok;
  wdt_pkg::wdt_cnt_word_t wword;
  wdt_pkg::wdt_status_t status;

  // ***************************************
  // tick divider
  // ***************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // ***************************************
  // apb decode
  // ***************************************
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & pready_q;
  assign wword = wdt_pkg::wdt_cnt_word_t'(PWDATA_I);
  assign guard_ok = (wword.write_guard_field == '0);
  assign cnt_wr = wr_en & (PADDR_I == `WDT_OFS_CNT) & guard_ok;

  always_comb begin
    case (PADDR_I)
      `WDT_OFS_CNT, `WDT_OFS_CTRL, `WDT_OFS_FRZ_SET, `WDT_OFS_FRZ_CLR,
      `WDT_OFS_IRQ_STAT, `WDT_OFS_IRQ_MASK, `WDT_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ***************************************
  // freeze and mode
  // ***************************************
  assign frozen = DEBUG_HALT_STATUS_I | (sw_frz_q & !sel_q);
  assign count_en = tick_q & !frozen & !rst_req_q;
  assign cnt_dec = cnt_q - `WDT_CNT_ONE;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      sel_q <= 1'b0;
    end else if (wr_en && PADDR_I == `WDT_OFS_CTRL && PWDATA_I[`WDT_BIT_SEL]) begin
      sel_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      sw_frz_q <= 1'b0;
    end else if (wr_en && PADDR_I == `WDT_OFS_FRZ_SET && PWDATA_I[`WDT_BIT_FRZ]) begin
      sw_frz_q <= 1'b1;
    end else if (wr_en && PADDR_I == `WDT_OFS_FRZ_CLR && PWDATA_I[`WDT_BIT_FRZ]) begin
      sw_frz_q <= 1'b0;
    end
  end

  // ***************************************
  // counter
  // ***************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      cnt_q <= `WDT_CNT_RST;
    end else if (cnt_wr) begin
      cnt_q <= wword.value;
    end else if (count_en) begin
      cnt_q <= cnt_dec;
    end
  end

  // ***************************************
  // nmi and reset request
  // ***************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= count_en & !cnt_wr & !sel_q & (cnt_dec == `WDT_CNT_ZERO);
    end
  end

  // request holds until the system reset comes back
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      rst_req_q <= 1'b0;
    end else if (count_en && !cnt_wr) begin
      if (sel_q) begin
        if ($signed(cnt_dec) <= $signed(`WDT_CNT_ZERO)) begin
          rst_req_q <= 1'b1;
        end
      end else if ($signed(cnt_dec) <= $signed(`WDT_CNT_NEG_LIM)) begin
        rst_req_q <= 1'b1;
      end
    end
  end

  // ***************************************
  // interrupt status and mask
  // ***************************************
  assign stat_set = {wr_en & (PADDR_I == `WDT_OFS_CNT) & !guard_ok, nmi_q};

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      stat_q <= '0;
    end else if (wr_en && PADDR_I == `WDT_OFS_IRQ_STAT) begin
      stat_q <= (stat_q & ~PWDATA_I[`WDT_IRQ_W-1:0]) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      mask_q <= '0;
    end else if (wr_en && PADDR_I == `WDT_OFS_IRQ_MASK) begin
      mask_q <= PWDATA_I[`WDT_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ***************************************
  // apb read and ready
  // ***************************************
  assign status = '{reset_req: rst_req_q, sw_frozen: sw_frz_q & !sel_q,
                    debug_frozen: DEBUG_HALT_STATUS_I};

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      pready_q <= PSEL_I & !PENABLE_I;
      pslverr_q <= PSEL_I & !PENABLE_I & !mapped;
      rdata_q <= '0;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        case (PADDR_I)
          `WDT_OFS_CNT: rdata_q <= {23'h000000, cnt_q};
          `WDT_OFS_CTRL: rdata_q <= {31'h00000000, sel_q};
          `WDT_OFS_IRQ_STAT: rdata_q <= {30'h00000000, stat_q};
          `WDT_OFS_IRQ_MASK: rdata_q <= {30'h00000000, mask_q};
          `WDT_OFS_STATUS: rdata_q <= {29'h00000000, status};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign PRDATA_O = rdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign NMI_O = nmi_q;
  assign SYS_RST_REQ_O = rst_req_q;
  assign IRQ_O = irq_q;

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  a_tick_period: assert property (tick_q |-> $past(div_q) == DIV_W'(TICK_CYCLES - 1))
    else $error("tick not at divider wrap");
  a_cnt_step: assert property (count_en && !cnt_wr |=> cnt_q == $past(cnt_q) - `WDT_CNT_ONE)
    else $error("counter did not step by one");
  a_reset_load: assert property (disable iff (1'b0) !RESETN_I |=> cnt_q == `WDT_CNT_RST)
    else $error("counter not 255 after reset");
  a_guard_reject: assert property (wr_en && PADDR_I == `WDT_OFS_CNT && !guard_ok && !count_en
      |=> $stable(cnt_q))
    else $error("guarded write changed counter");
  a_neg_wrap: assert property (count_en && !cnt_wr && cnt_q == `WDT_CNT_ZERO |=> cnt_q == 9'h1ff)
    else $error("zero did not wrap to minus one");
  a_nmi_zero: assert property (count_en && !cnt_wr && !sel_q && cnt_dec == `WDT_CNT_ZERO
      |=> NMI_O ##1 !NMI_O)
    else $error("interrupt missing at zero");
  a_rst_neg: assert property (count_en && !cnt_wr && !sel_q && cnt_dec == `WDT_CNT_NEG_LIM
      |=> SYS_RST_REQ_O)
    else $error("reset missing at minus sixteen");
  a_rst_zero: assert property (count_en && !cnt_wr && sel_q && cnt_dec == `WDT_CNT_ZERO
      |=> SYS_RST_REQ_O && !NMI_O)
    else $error("reset-at-zero mode misbehaved");
  a_debug_hold: assert property (DEBUG_HALT_STATUS_I && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved in debug halt");
  a_sw_hold: assert property (sw_frz_q && !sel_q && !cnt_wr |=> $stable(cnt_q) && !NMI_O)
    else $error("counter moved under software freeze");
  a_frz_release: assert property (wr_en && PADDR_I == `WDT_OFS_FRZ_CLR && PWDATA_I[`WDT_BIT_FRZ]
      |=> !sw_frz_q)
    else $error("freeze clear ignored");
  a_sel_sticky: assert property (sel_q |=> sel_q)
    else $error("mode bit cleared without reset");

  c_nmi: cover property (NMI_O);
  c_rst_mode0: cover property (SYS_RST_REQ_O && !sel_q);
  c_rst_mode1: cover property (SYS_RST_REQ_O && sel_q);
  c_debug_halt: cover property (tick_q && DEBUG_HALT_STATUS_I);
endmodule : wdt_top

// [verification/wdt_core_model.sv]
// Purpose: core side: debug halt and reset feedback
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
module wdt_core_model (
  input wire logic por_n_i,
  input wire logic halt_i,
  input wire logic rst_req_i,
  output logic resetn_o,
  output logic halt_o
);
  assign resetn_o = por_n_i & ~rst_req_i;
  assign halt_o = halt_i;
endmodule : wdt_core_model

// [verification/tb_wdt_top.sv]
// Purpose: self-checking bench of the watchdog
// Assumes: TICK_CYCLES shortened to 4
// Notes: reset request fed back by the core model
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module tb_wdt_top;
  logic clk = 0, por_n = 0, halt = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000, prd, rd;
  logic rstn, dbg, prdy, perr, nmi, rreq, irq, e;
  int fails = 0, compares = 0, nmis = 0, n, k0;
  logic [44:0] rows [7] = '{{`WDT_OFS_CNT, 32'h000000ff, 1'b0}, {`WDT_OFS_CTRL, 32'h0, 1'b0},
    {`WDT_OFS_STATUS, 32'h0, 1'b0}, {`WDT_OFS_IRQ_STAT, 32'h0, 1'b0},
    {`WDT_OFS_IRQ_MASK, 32'h0, 1'b0}, {`WDT_OFS_FRZ_SET, 32'h0, 1'b0}, {12'h020, 32'h0, 1'b1}};
  always #20 clk = ~clk;
  always @(posedge clk) if (nmi === 1'b1) nmis++;
  wdt_core_model wdt_core_model_inst (.por_n_i(por_n), .halt_i(halt), .rst_req_i(rreq),
    .resetn_o(rstn), .halt_o(dbg));
  wdt_top #(.TICK_CYCLES(4)) wdt_top_inst (.CLK_SYS_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .DEBUG_HALT_STATUS_I(dbg),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .NMI_O(nmi), .SYS_RST_REQ_O(rreq),
    .IRQ_O(irq));
  // ****
  // tasks
  // ****
  task final_report;
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task chk_rng(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      fails++;
      $display("wrong value at %0t: %0d cycles", $time, v);
    end
  endtask : chk_rng
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 50);
    if (k >= 50) fails++;
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdchk
  task wait_for(input logic s, input int lim);
    n = 0;
    while ((s ? rreq : nmi) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_for
  task irq_is(input logic x);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask : irq_is
  // ****
  // tests
  // ****
  initial begin
    #400000;
    fails++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdchk(rows[i][44:33], rows[i][32:1]);
      chk({31'h0, e}, {31'h0, rows[i][0]});
    end
    apb(1'b1, `WDT_OFS_FRZ_SET, 32'h1);
    apb(1'b1, `WDT_OFS_CNT, 32'h5);
    repeat (12) @(posedge clk);
    rdchk(`WDT_OFS_CNT, 32'h5);
    rdchk(`WDT_OFS_STATUS, 32'h2);
    apb(1'b1, `WDT_OFS_CNT, 32'h0000fe03);
    rdchk(`WDT_OFS_CNT, 32'h5);
    irq_is(1'b0);
    apb(1'b1, `WDT_OFS_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    apb(1'b1, `WDT_OFS_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    halt <= 1'b1;
    apb(1'b1, `WDT_OFS_FRZ_CLR, 32'h1);
    apb(1'b1, `WDT_OFS_IRQ_MASK, 32'h1);
    repeat (12) @(posedge clk);
    rdchk(`WDT_OFS_CNT, 32'h5);
    halt <= 1'b0;
    wait_for(1'b0, 24);
    chk_rng(n, 18, 23);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wait_for(1'b1, 64);
    chk_rng(n, 59, 63);
    repeat (3) @(posedge clk);
    rdchk(`WDT_OFS_CNT, 32'hff);
    rdchk(`WDT_OFS_IRQ_STAT, 32'h0);
    // handler reload after the interrupt keeps reset away
    apb(1'b1, `WDT_OFS_CNT, 32'h1);
    wait_for(1'b0, 12);
    chk_rng(n, 1, 11);
    apb(1'b1, `WDT_OFS_CNT, 32'h5);
    wait_for(1'b0, 24);
    chk_rng(n, 18, 23);
    chk({31'h0, rreq}, 32'h0);
    apb(1'b1, `WDT_OFS_CNT, 32'hff);
    apb(1'b1, `WDT_OFS_CTRL, 32'h1);
    apb(1'b1, `WDT_OFS_CTRL, 32'h0);
    rdchk(`WDT_OFS_CTRL, 32'h1);
    apb(1'b1, `WDT_OFS_FRZ_SET, 32'h1);
    apb(1'b1, `WDT_OFS_CNT, 32'h2);
    k0 = nmis;
    wait_for(1'b1, 13);
    chk_rng(n, 2, 12);
    chk_rng(nmis - k0, 0, 0);
    repeat (3) @(posedge clk);
    rdchk(`WDT_OFS_CTRL, 32'h0);
    final_report();
  end
endmodule : tb_wdt_top
